// File: src/sac_pkg.sv
// constants, types and timing counts shared by the converter control block
// assumes a single 200 MHz clock and a synchronous active-high reset

package sac_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_NS        = 5;     // clock period in ns
  localparam int ACQ_FAST_NS   = 250;   // least acquisition, fastest mode
  localparam int ACQ_STD_NS    = 300;   // least acquisition, standard mode
  localparam int ACQ_LOW_NS    = 450;   // acquisition incl. wake, low power
  localparam int STEP_NS       = 60;    // least settle time of one trial step
  // least times round up to whole cycles
  localparam int ACQ_FAST_CYC  = (ACQ_FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACQ_STD_CYC   = (ACQ_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACQ_LOW_CYC   = (ACQ_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_CYC      = (STEP_NS + CLK_NS - 1) / CLK_NS;

  // ************************************************************
  // word layout and codes
  // ************************************************************
  localparam int        RES_BITS  = 16;       // trial steps per conversion
  localparam logic [15:0] MSB_TRIAL = 16'h8000; // first trial, midscale
  localparam logic [15:0] CODE_MAX  = 16'hFFFF; // straight binary maximum
  localparam logic [15:0] CODE_MIN  = 16'h0000; // straight binary minimum
  localparam logic [15:0] SIGN_FLIP = 16'h8000; // binary to twos complement
  localparam logic [15:0] WORD_RST  = 16'h0000; // reset value of words

  typedef logic [7:0] sac_cnt_t;                // cycle counter

  // operating modes on the mode select input
  typedef enum logic [1:0] {
    SAC_MODE_FAST = 2'b00,
    SAC_MODE_STD  = 2'b01,
    SAC_MODE_LOW  = 2'b10
  } sac_mode_e;

  // control states
  typedef enum logic [2:0] {
    SAC_ST_ACQ   = 3'b000,  // array tracks the input
    SAC_ST_READY = 3'b001,  // acquisition done, waiting for start
    SAC_ST_TRIAL = 3'b010,  // successive approximation running
    SAC_ST_LATCH = 3'b011,  // result waiting to enter the buffer
    SAC_ST_PDOWN = 3'b100   // powered down, starts blocked
  } sac_state_e;

endpackage

// File: src/sac_stream_if.sv
// valid/ready word carrier between the control block and its buffer
// assumes both ends run on the same clock

`timescale 1ns/1ps

interface sac_stream_if #(
  parameter int W = 16
);
  logic         valid;  // word offered
  logic         ready;  // word can be taken
  logic [W-1:0] data;   // the word

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: src/sac_pair_buf.sv
// small result buffer with valid and ready on both sides
// assumes one clock; depth is a power of two

`timescale 1ns/1ps

module sac_pair_buf #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input  wire logic   clk,
  input  wire logic   rst,
  sac_stream_if.snk   fill,
  sac_stream_if.src   drain
);

  localparam int PW = $clog2(DEPTH);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;    // stored words
    logic [PW-1:0]           wr;     // write pointer
    logic [PW-1:0]           rd;     // read pointer
    logic [PW:0]             count;  // words held
  } sac_buf_s;

  sac_buf_s st_q;   // registered state
  sac_buf_s st_d;   // next state
  logic     push;   // word enters
  logic     pop;    // word leaves

  // full refuses the filler, which stalls the converter
  assign fill.ready  = (st_q.count < (PW+1)'(DEPTH));
  assign drain.valid = (st_q.count != '0);
  assign drain.data  = st_q.mem[st_q.rd];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  // next state: write, read, count
  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.mem[st_q.wr] = fill.data;
      st_d.wr           = st_q.wr + 1'b1;
    end
    if (pop)
    begin
      st_d.rd = st_q.rd + 1'b1;
    end
    // simultaneous push and pop leave the count alone
    st_d.count = st_q.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule // sac_pair_buf

// File: src/sac_conv_ctrl.sv
// control logic of a 16-bit successive-approximation converter
// assumes an analog comparator and switch array outside; one 200 MHz clock
// Behaviour
// - start after acquisition on low start input
// - sixteen binary trials, most significant first
// - form final word, then drop busy
// - result belongs to this sample, no latency
// - three modes: fastest, standard, low power
// - standard mode has no idle limit
// - low power saves between conversions, slower throughput
// - coding select picks binary or twos complement
// - midscale 8000 binary, 0000 twos complement
// - over range gives max, under gives min
// - busy high from start until result latched
// - reset aborts any conversion
// - power down finishes conversion, then blocks

`timescale 1ns/1ps

module sac_conv_ctrl #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic        clk,                  // 200 MHz clock
  input  wire logic        rst,                  // synchronous reset
  input  wire logic        conversion_start_n,   // start, active low
  input  wire logic        output_coding_select, // 1 binary, 0 twos comp
  input  wire logic        power_down_request,   // power down
  input  wire logic [1:0]  mode_select,          // operating mode
  input  wire logic        comp_keep,            // sample >= trial code
  input  wire logic        over_range,           // input above full scale
  input  wire logic        under_range,          // input below full scale
  output logic             busy,                 // conversion in progress
  output logic             hold,                 // sample held
  output logic             array_ground_switch,  // 1: array to ground
  output logic             power_save,           // analog power reduced
  output logic [15:0]      trial_code,           // switch array setting
  output logic             result_valid,         // result word offered
  input  wire logic        result_ready,         // host takes the word
  output logic [15:0]      result_data           // result word
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    sac_pkg::sac_state_e state;   // control state
    sac_pkg::sac_cnt_t   cnt;     // cycles left in phase
    logic [3:0]          idx;     // bit under trial
    logic [15:0]         sar;     // trial register
    logic                pend;    // falling start seen during acquisition
    logic                start_p; // start input one cycle ago
    logic                busy;    // busy flag
    logic [15:0]         word;    // coded result
  } sac_ctrl_s;

  sac_ctrl_s st_q;                // registered state
  sac_ctrl_s st_d;                // next state

  sac_stream_if #(.W(16)) to_buf ();   // control to buffer
  sac_stream_if #(.W(16)) from_buf (); // buffer to host

  // ************************************************************
  // helpers
  // ************************************************************
  // acquisition length per mode; an unused code behaves as standard
  function automatic sac_pkg::sac_cnt_t acq_len(input logic [1:0] m);
    sac_pkg::sac_cnt_t n;
    n = sac_pkg::sac_cnt_t'(sac_pkg::ACQ_STD_CYC - 1);
    if (m == sac_pkg::SAC_MODE_FAST)
      n = sac_pkg::sac_cnt_t'(sac_pkg::ACQ_FAST_CYC - 1);
    else if (m == sac_pkg::SAC_MODE_LOW)
      n = sac_pkg::sac_cnt_t'(sac_pkg::ACQ_LOW_CYC - 1);
    return n;
  endfunction

  // one-hot weight of a trial bit
  function automatic logic [15:0] bit_w(input logic [3:0] i);
    return 16'h0001 << i;
  endfunction

  logic start_now;   // start condition in ready state
  logic [15:0] raw;  // final straight binary code after saturation
  logic accepted;    // buffer took the word

  assign start_now = !conversion_start_n || st_q.pend;
  assign accepted  = to_buf.valid && to_buf.ready;

  // saturating decision of the last trial, straight binary
  always_comb
  begin
    raw = comp_keep ? st_q.sar : (st_q.sar & ~bit_w(st_q.idx));
    if (over_range)
      raw = sac_pkg::CODE_MAX;
    else if (under_range)
      raw = sac_pkg::CODE_MIN;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    st_d         = st_q;
    st_d.start_p = conversion_start_n;
    unique case (st_q.state)
      sac_pkg::SAC_ST_ACQ:
      begin
        // remember a short start pulse during acquisition; set only here
        if (st_q.start_p && !conversion_start_n)
          st_d.pend = 1'b1;
        if (power_down_request)
        begin
          st_d.state = sac_pkg::SAC_ST_PDOWN;
          st_d.pend  = 1'b0;
        end
        else if (st_q.cnt == '0)
          st_d.state = sac_pkg::SAC_ST_READY;
        else
          st_d.cnt = st_q.cnt - 1'b1;
      end
      sac_pkg::SAC_ST_READY:
      begin
        // level start: held low at acquisition end starts at once
        if (power_down_request)
        begin
          st_d.state = sac_pkg::SAC_ST_PDOWN;
          st_d.pend  = 1'b0;
        end
        else if (start_now)
        begin
          st_d.state = sac_pkg::SAC_ST_TRIAL;
          st_d.pend  = 1'b0;
          st_d.busy  = 1'b1;
          st_d.sar   = sac_pkg::MSB_TRIAL;
          st_d.idx   = 4'(sac_pkg::RES_BITS - 1);
          st_d.cnt   = sac_pkg::sac_cnt_t'(sac_pkg::STEP_CYC - 1);
        end
      end
      sac_pkg::SAC_ST_TRIAL:
      begin
        // power down is ignored here: the running conversion completes
        if (st_q.cnt != '0)
          st_d.cnt = st_q.cnt - 1'b1;
        else if (st_q.idx != 4'h0)
        begin
          // keep or drop this bit, then try the next lower one
          st_d.sar = (comp_keep ? st_q.sar
                                : (st_q.sar & ~bit_w(st_q.idx)))
                     | bit_w(st_q.idx - 1'b1);
          st_d.idx = st_q.idx - 1'b1;
          st_d.cnt = sac_pkg::sac_cnt_t'(sac_pkg::STEP_CYC - 1);
        end
        else
        begin
          // last step: code formed from this very sample
          st_d.sar   = raw;
          st_d.word  = output_coding_select ? raw
                       : (raw ^ sac_pkg::SIGN_FLIP);
          st_d.state = sac_pkg::SAC_ST_LATCH;
        end
      end
      sac_pkg::SAC_ST_LATCH:
      begin
        // busy stays up while the buffer is full, so no word is lost
        if (accepted)
        begin
          st_d.busy = 1'b0;
          st_d.cnt  = acq_len(mode_select);
          st_d.state = power_down_request ? sac_pkg::SAC_ST_PDOWN
                                          : sac_pkg::SAC_ST_ACQ;
        end
      end
      sac_pkg::SAC_ST_PDOWN:
      begin
        // starts are blocked until the request is withdrawn
        if (!power_down_request)
        begin
          st_d.state = sac_pkg::SAC_ST_ACQ;
          st_d.cnt   = acq_len(mode_select);
        end
      end
      default:
      begin
        st_d.state = sac_pkg::SAC_ST_ACQ;
      end
    endcase
  end

  // state register; reset drops any conversion at once
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q.state   <= sac_pkg::SAC_ST_ACQ;
      st_q.cnt     <= sac_pkg::sac_cnt_t'(sac_pkg::ACQ_STD_CYC - 1);
      st_q.idx     <= 4'h0;
      st_q.sar     <= sac_pkg::WORD_RST;
      st_q.pend    <= 1'b0;
      st_q.start_p <= 1'b1;
      st_q.busy    <= 1'b0;
      st_q.word    <= sac_pkg::WORD_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // outputs and buffer
  // ************************************************************
  assign busy                = st_q.busy;
  assign hold                = st_q.busy;
  assign array_ground_switch = (st_q.state == sac_pkg::SAC_ST_ACQ) ||
                               (st_q.state == sac_pkg::SAC_ST_READY);
  // low power idles the analog part while waiting for a start
  assign power_save = (st_q.state == sac_pkg::SAC_ST_PDOWN) ||
                      ((st_q.state == sac_pkg::SAC_ST_READY) &&
                       (mode_select == sac_pkg::SAC_MODE_LOW));
  assign trial_code          = st_q.sar;
  assign to_buf.valid        = (st_q.state == sac_pkg::SAC_ST_LATCH);
  assign to_buf.data         = st_q.word;
  assign result_valid        = from_buf.valid;
  assign result_data         = from_buf.data;
  assign from_buf.ready      = result_ready;

  sac_pair_buf #(
    .W     (16),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk   (clk),
    .rst   (rst),
    .fill  (to_buf),
    .drain (from_buf)
  );

  // ************************************************************
  // checks
  // ************************************************************
  localparam int MIN_CONV = 192;   // sixteen steps of twelve cycles
  int unsigned busy_len;           // cycles busy has been high

  always_ff @(posedge clk)
  begin
    if (rst || !st_q.busy)
      busy_len <= 0;
    else
      busy_len <= busy_len + 1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence ready_and_start;
    (st_q.state == sac_pkg::SAC_ST_READY) && !conversion_start_n &&
    !power_down_request;
  endsequence

  sequence word_taken;
    to_buf.valid && to_buf.ready;
  endsequence

  // half of the first step; two in a row cover all twelve cycles
  sequence msb_held;
    (trial_code == 16'h8000) [*6];
  endsequence

  // last decision of a conversion with the input below full scale
  sequence under_last;
    (st_q.state == sac_pkg::SAC_ST_TRIAL) && under_range && !over_range &&
    (st_q.idx == 4'h0) && (st_q.cnt == '0);
  endsequence

  start_go_a: assert property (ready_and_start |=> busy ##0
    (trial_code == 16'h8000))
    else $error("start not taken after acquisition");
  msb_first_a: assert property ($rose(busy) |->
    msb_held ##1 msb_held ##1 (trial_code[15:14] != 2'b00))
    else $error("first trial not on the top bit");
  full_length_a: assert property ($fell(busy) |->
    $past(busy_len) >= MIN_CONV - 1)
    else $error("conversion ended before sixteen steps");
  word_then_idle_a: assert property (word_taken |=> !busy)
    else $error("busy stayed high after word latched");
  busy_latch_a: assert property ($fell(busy) |->
    $past(to_buf.valid && to_buf.ready))
    else $error("busy fell without a latched word");
  coding_pick_a: assert property (to_buf.valid |->
    (to_buf.data == (output_coding_select ? st_q.sar :
     st_q.sar ^ 16'h8000)))
    else $error("result coding does not match select");
  over_max_a: assert property (((st_q.state == sac_pkg::SAC_ST_TRIAL) &&
    over_range && (st_q.idx == 4'h0) && (st_q.cnt == '0)) |=>
    (trial_code == 16'hFFFF))
    else $error("over range did not give maximum code");
  under_min_a: assert property (under_last |=>
    (trial_code == 16'h0000))
    else $error("under range did not give minimum code");
  pdown_block_a: assert property (
    (st_q.state == sac_pkg::SAC_ST_PDOWN) && power_down_request
    |=> !busy && power_save)
    else $error("conversion ran during power down");
  reset_abort_a: assert property ($fell(rst) |-> !busy &&
    array_ground_switch)
    else $error("reset did not abort conversion");
  low_save_a: assert property (((st_q.state == sac_pkg::SAC_ST_READY) &&
    (mode_select == 2'b10)) |-> power_save)
    else $error("low power mode not saving while idle");

endmodule // sac_conv_ctrl

// File: test/sac_host_model.sv
// host model: issues conversion starts and takes result words
// assumes one clock shared with the converter; drives 1 ns after the edge
`timescale 1ns/1ps

module sac_host_model #(
  parameter int IDLE_LIMIT = 200000 // 1 ms of idle at 200 MHz
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start_want,     // bench asks for conversions
  input  wire logic stall,          // bench holds reads off
  input  wire logic fast_mode,      // converter in the fastest mode
  input  wire logic busy,           // converter busy flag
  output logic      conversion_start_n,
  output logic      result_ready,
  output logic      discard_next    // next fast-mode word is untrusted
);
  int idle;                         // cycles since the last conversion

  initial
  begin
    conversion_start_n = 1'b1;
    result_ready = 1'b0;
    discard_next = 1'b0;
    idle = 0;
  end

  // ****************************************
  // start level and read handshake
  // ****************************************
  // start is a held level, so the converter paces back to back runs and
  // the host never asks for more than a mode allows
  always @(posedge clk)
  begin
    conversion_start_n <= #1 !start_want;
    result_ready <= #1 !stall && !rst;
  end

  // long idle in the fastest mode spoils the next result
  always @(posedge clk)
  begin
    idle <= busy ? 0 : idle + 1;
    discard_next <= #1 fast_mode && (idle > IDLE_LIMIT);
  end
endmodule // sac_host_model

// File: test/sac_conv_ctrl_tb_top.sv
// self-checking bench for the converter control block
// assumes the src files and the host model are compiled first
`timescale 1ns/1ps

module sac_conv_ctrl_tb_top;
  // ****************************************
  // signals
  // ****************************************
  localparam int BUSY_W = sac_pkg::RES_BITS * sac_pkg::STEP_CYC + 1;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start_want = 1'b0; // host should start conversions
  logic        stall = 1'b0;      // host holds reads off
  logic        coding = 1'b1;     // output coding choice
  logic        pdown = 1'b0;      // power down request
  logic [1:0]  mode = 2'b01;      // operating mode
  logic [15:0] sample = 16'h0000; // held input as an ideal code
  logic        ov = 1'b0;         // input above full scale
  logic        un = 1'b0;         // input below full scale
  logic        bw_on = 1'b1;      // busy width is checked
  logic        start_n, ready, busy, hold, ags, psave, rvalid;
  logic        busy_d = 1'b0, ps_seen = 1'b0, ps_last = 1'b0;
  logic [15:0] trial, rdata;
  logic [15:0] exp_q[$];          // words the model expects, in order
  int          gap = 0, last_gap = 0, bw = 0;
  int          miscompares = 0, n_tests = 0;
  int          acq[3] = '{sac_pkg::ACQ_FAST_CYC, sac_pkg::ACQ_STD_CYC,
                          sac_pkg::ACQ_LOW_CYC};
  logic [15:0] codes[6] = '{16'h8000, 16'h8001, 16'h7FFF, 16'hFFFF,
                            16'h0000, 16'h0001};
  wire logic   comp_keep = (sample >= trial); // ideal comparator

  always #2.5 clk = ~clk;

  sac_conv_ctrl dut (.clk(clk), .rst(rst), .conversion_start_n(start_n),
    .output_coding_select(coding), .power_down_request(pdown),
    .mode_select(mode), .comp_keep(comp_keep), .over_range(ov),
    .under_range(un), .busy(busy), .hold(hold),
    .array_ground_switch(ags), .power_save(psave), .trial_code(trial),
    .result_valid(rvalid), .result_ready(ready), .result_data(rdata));

  sac_host_model host (.clk(clk), .rst(rst), .start_want(start_want),
    .stall(stall), .fast_mode(mode == 2'b00), .busy(busy),
    .conversion_start_n(start_n), .result_ready(ready),
    .discard_next());

  // ****************************************
  // model and checking
  // ****************************************
  // ideal word: range flags first (over wins), then sign flip for twos
  function automatic logic [15:0] model_word(int s, bit c, bit o, bit u);
    int v;
    v = o ? 65535 : (u ? 0 : s);
    if (!c)
      v = v ^ 32768;
    return 16'(v);
  endfunction

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // watch busy edges, gaps and every word the host takes
  always @(posedge clk)
  begin
    busy_d <= busy;
    if (rst)
    begin
      exp_q.delete();
      gap <= 0;
    end
    else if (busy === 1'b1 && busy_d !== 1'b1)
    begin
      exp_q.push_back(model_word(sample, coding, ov, un));
      last_gap <= gap;
      ps_last <= ps_seen;
      ps_seen <= 1'b0;
      bw <= 1;
      gap <= 0;
    end
    else if (busy === 1'b1)
      bw <= bw + 1;
    else
    begin
      gap <= gap + 1;
      if (psave === 1'b1)
        ps_seen <= 1'b1;
      if (busy_d === 1'b1)
      begin
        check("word at busy fall", {15'h0, rvalid}, 16'h0001);
        if (bw_on)
          check("busy width", 16'(bw), 16'(BUSY_W));
      end
    end
    if (!rst && rvalid === 1'b1 && ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("spare word", {15'h0, rvalid}, 16'h0000);
      else
        check("result_data", rdata, exp_q.pop_front());
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    @(posedge clk);
    while (busy !== lvl && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= lim)
      check("busy wait", {15'h0, busy}, {15'h0, lvl});
    #1;
  endtask

  task automatic check_idle();
    check("busy idle", {15'h0, busy}, 16'h0000);
    check("hold idle", {15'h0, hold}, 16'h0000);
    check("array grounded", {15'h0, ags}, 16'h0001);
    check("trial cleared", trial, 16'h0000);
    check("no word", {15'h0, rvalid}, 16'h0000);
  endtask

  // one conversion; fin low returns early in the second trial step
  task automatic conv(input logic [15:0] s, input logic c, input logic o,
                      input logic u, input logic fin);
    sample = s;
    coding = c;
    ov = o;
    un = u;
    start_want = 1'b1;
    wait_busy(1'b1, 600);
    start_want = 1'b0;
    check("first trial", trial, sac_pkg::MSB_TRIAL);
    check("array open", {15'h0, ags}, 16'h0000);
    check("sample held", {15'h0, hold}, 16'h0001);
    repeat (sac_pkg::STEP_CYC + 2) @(posedge clk);
    #1;
    check("second trial", {14'h0, trial[15:14]}, {14'h0, s[15], 1'b1});
    if (fin)
      wait_busy(1'b0, 2000);
  endtask

  task automatic done(string name);
    $display("test %s done", name);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard, about four times the expected run
  initial
  begin
    #200000;
    miscompares++;
    $display("[ERR] watchdog expected done seen hang");
    close_out();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(86));
    repeat (10) @(posedge clk);
    #1;
    check_idle();
    start_want = 1'b1; // held low while acquisition runs
    rst = 1'b0;
    conv(16'h1234, 1'b1, 1'b0, 1'b0, 1'b1);
    check("acq after reset", 16'(last_gap >= acq[1]), 16'h0001);
    done("start_after_reset");
    foreach (codes[i])
      for (int c = 0; c < 2; c++)
        conv(codes[i], c[0], 1'b0, 1'b0, 1'b1);
    repeat (4) conv(16'($urandom), 1'($urandom), 1'b0, 1'b0, 1'b1);
    done("codes");
    for (int k = 1; k < 4; k++)
      for (int c = 0; c < 2; c++)
        conv(16'($urandom), c[0], k[0], k[1], 1'b1);
    done("range");
    for (int m = 0; m < 3; m++)
    begin
      mode = 2'(m);
      conv(16'($urandom), 1'b1, 1'b0, 1'b0, 1'b1);
      conv(16'($urandom), 1'b1, 1'b0, 1'b0, 1'b1);
      check("acq gap", 16'(last_gap >= acq[m]), 16'h0001);
      check("saving in ready", {15'h0, ps_last}, 16'(m == 2));
    end
    mode = 2'b01;
    done("modes");
    bw_on = 1'b0;
    stall = 1'b1;
    conv(16'h0F0F, 1'b1, 1'b0, 1'b0, 1'b1);
    conv(16'hF0F0, 1'b0, 1'b0, 1'b0, 1'b1);
    conv(16'h5A5A, 1'b1, 1'b0, 1'b0, 1'b0);
    repeat (400) @(posedge clk);
    #1;
    check("stuck in latch", {15'h0, busy}, 16'h0001);
    check("head stands", rdata, 16'h0F0F);
    stall = 1'b0;
    wait_busy(1'b0, 100);
    repeat (5) @(posedge clk);
    #1;
    check("buffer drained", 16'(exp_q.size()), 16'h0000);
    bw_on = 1'b1;
    done("buffer_stall");
    conv(16'hC3C3, 1'b1, 1'b0, 1'b0, 1'b0);
    repeat (50) @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check_idle();
    rst = 1'b0;
    conv(16'h3C3C, 1'b0, 1'b0, 1'b0, 1'b1);
    done("reset_abort");
    conv(16'h2222, 1'b1, 1'b0, 1'b0, 1'b0);
    pdown = 1'b1;
    start_want = 1'b1;
    wait_busy(1'b0, 2000);
    repeat (300)
    begin
      @(posedge clk);
      if (busy !== 1'b0)
        check("start blocked", {15'h0, busy}, 16'h0000);
    end
    #1;
    check("power saved", {15'h0, psave}, 16'h0001);
    pdown = 1'b0;
    wait_busy(1'b1, 600);
    start_want = 1'b0;
    wait_busy(1'b0, 2000);
    done("power_down");
    repeat (10) @(posedge clk);
    check("queue empty", 16'(exp_q.size()), 16'h0000);
    close_out();
  end
endmodule // sac_conv_ctrl_tb_top
